// ==== core/debug_support_pkg.sv ====
// Shared constants and types of the debug support register block.
package debug_support_pkg;

	// Byte addresses of the two registers on the Wishbone bus.
	localparam logic [31:0] CHIP_IDENTIFICATION_ADDR    = 32'hE004_2000;
	localparam logic [31:0] DEBUG_BEHAVIOUR_CONFIG_ADDR = 32'hE004_2004;

	// Only whole 32-bit words are accepted.
	localparam logic [3:0]  FULL_WORD_SEL = 4'hF;

	// Configuration reset value and the bits that software can hold.
	localparam logic [31:0] CONFIG_RESET      = 32'h0000_0000;
	localparam logic [31:0] CONFIG_WRITE_MASK = 32'h003F_FFE7;

	// Field positions of the identification word.
	localparam int          ID_DEVICE_LSB  = 0;
	localparam int          ID_RESERVED_LSB = 12;
	localparam int          ID_WAFER_LSB   = 16;
	localparam logic [3:0]  ID_RESERVED    = 4'h0;

	// Field positions of the configuration word.
	localparam int          CFG_SLEEP_POS      = 0;
	localparam int          CFG_HALT_LP_POS    = 1;
	localparam int          CFG_DEEP_LP_POS    = 2;
	localparam int          CFG_TRACE_ON_POS   = 5;
	localparam int          CFG_TRACE_MODE_LSB = 6;
	localparam int          CFG_IWD_POS        = 8;
	localparam int          CFG_WWD_POS        = 9;
	localparam int          CFG_TIMER_LO_LSB   = 10;
	localparam int          CFG_CAN1_POS       = 14;
	localparam int          CFG_SMBUS1_POS     = 15;
	localparam int          CFG_SMBUS2_POS     = 16;
	localparam int          CFG_TIMER_HI_LSB   = 17;
	localparam int          CFG_CAN2_POS       = 21;

	// Trace pin modes and the data lanes each one uses.
	localparam logic [1:0]  TRACE_MODE_ASYNC = 2'h0;
	localparam logic [1:0]  TRACE_MODE_SYNC1 = 2'h1;
	localparam logic [1:0]  TRACE_MODE_SYNC2 = 2'h2;
	localparam logic [1:0]  TRACE_MODE_SYNC4 = 2'h3;
	localparam logic [2:0]  TRACE_LANES_NONE = 3'h0;
	localparam logic [2:0]  TRACE_LANES_ONE  = 3'h1;
	localparam logic [2:0]  TRACE_LANES_TWO  = 3'h2;
	localparam logic [2:0]  TRACE_LANES_FOUR = 3'h4;

	// Power state reported by the power controller.
	typedef enum logic [1:0] {
		POWER_RUN,
		POWER_SLEEP,
		POWER_HALT_LOWPOWER,
		POWER_DEEP_LOWPOWER
	} power_mode_type;

	// Configuration word, most significant field first.
	typedef struct packed {
		logic [9:0] reserved_high;
		logic       second_can_freeze;
		logic [3:0] timer_freeze_high;
		logic       second_smbus_timeout_freeze;
		logic       first_smbus_timeout_freeze;
		logic       first_can_freeze;
		logic [3:0] timer_freeze_low;
		logic       window_watchdog_freeze;
		logic       independent_watchdog_freeze;
		logic [1:0] trace_mode;
		logic       trace_pins_on;
		logic [1:0] reserved_mid;
		logic       deep_lowpower_debug_clock_keep;
		logic       halt_lowpower_debug_clock_keep;
		logic       sleep_debug_clock_keep;
	} config_fields_type;

	// Complete state of the register block.
	typedef struct packed {
		config_fields_type cfg;
		logic              ack;
		logic              err;
		logic [31:0]       rdata;
		logic              core_clock_run;
		logic              ahb_clock_run;
		logic              rc_clock_source;
		logic [2:0]        trace_lanes;
	} slave_state_type;

	localparam slave_state_type STATE_RESET = '{
		cfg: config_fields_type'(CONFIG_RESET),
		ack: 1'b0,
		err: 1'b0,
		rdata: 32'h0000_0000,
		core_clock_run: 1'b1,
		ahb_clock_run: 1'b1,
		rc_clock_source: 1'b0,
		trace_lanes: TRACE_LANES_NONE
	};

endpackage

// ==== core/wb_word_decode.sv ====
// Address and byte-select decode for the two register words.
`timescale 1ns/10ps
module wb_word_decode
	import debug_support_pkg::*;
(
	input  wire logic [31:0] adr_i,     // Wishbone byte address.
	input  wire logic [3:0]  sel_i,     // Wishbone byte selects.
	output logic             hit_id_o,  // Identification word addressed.
	output logic             hit_cfg_o, // Configuration word addressed.
	output logic             bad_o      // Unmapped address or partial word.
);

	// A partial word or a foreign address is answered with an error.
	always_comb begin
		hit_id_o  = (adr_i == CHIP_IDENTIFICATION_ADDR) && (sel_i == FULL_WORD_SEL);
		hit_cfg_o = (adr_i == DEBUG_BEHAVIOUR_CONFIG_ADDR) && (sel_i == FULL_WORD_SEL);
		bad_o     = !(hit_id_o || hit_cfg_o);
	end

endmodule

// ==== core/freeze_stage.sv ====
// Registered gate of freeze enables with the core halted indication.
`timescale 1ns/10ps
module freeze_stage #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,    // Block clock.
	input  wire logic             rst_i,    // Synchronous reset, active high.
	input  wire logic [WIDTH-1:0] enable_i, // Freeze enables from configuration.
	input  wire logic             halted_i, // Core halted indication.
	output logic [WIDTH-1:0]      frozen_o  // Freeze outputs to the peripherals.
);

	logic [WIDTH-1:0] frozen_reg;
	logic [WIDTH-1:0] frozen_next;

	// A peripheral freezes only while its enable is set and the core is halted.
	always_comb begin
		frozen_next = rst_i ? '0 : (enable_i & {WIDTH{halted_i}}); // RULE_17
	end

	// The freeze flags are registered so the outputs come from flip-flops.
	always_ff @(posedge clk_i) begin
		frozen_reg <= frozen_next;
	end

	assign frozen_o = frozen_reg;

	// A running core never sees a frozen peripheral one cycle later.
	a_freeze_follow: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
		!halted_i |=> frozen_o == '0)
		else $error("freeze output set while core was running");

endmodule

// ==== core/debug_support_config_regs.sv ====
// Debug support registers: chip identification and debug behaviour config.
//
// What this block does
// RULE_01 - Identification bits 11:0 hold device code.
// RULE_02 - Bits 31:16 wafer revision, 15:12 reserved.
// RULE_03 - Accessors use whole 32-bit word accesses.
// RULE_04 - Config clears on power-on reset only.
// RULE_05 - Bit 0 picks debugged sleep clocks.
// RULE_06 - Bit 1 picks debugged halt low-power clocks.
// RULE_07 - Bit 2 picks debugged deep low-power clocks.
// RULE_08 - Bit 5 enables trace pins; 4:3 reserved.
// RULE_09 - Bits 7:6 trace mode, set while enabled.
// RULE_10 - Bit 8 freezes independent watchdog when halted.
// RULE_11 - Bit 9 freezes window watchdog when halted.
// RULE_12 - Bits 13:10, 20:17 freeze timers when halted.
// RULE_13 - Bit 14 freezes first CAN when halted.
// RULE_14 - Bit 15 freezes first SMBus timeout.
// RULE_15 - Bit 16 freezes second SMBus timeout.
// RULE_16 - Bit 21 freezes second CAN; 31:22 reserved.
// RULE_17 - Freeze equals bit AND halted; reserved zero.
`timescale 1ns/10ps
module debug_support_config_regs
	import debug_support_pkg::*;
#(
	parameter logic [11:0] DEVICE_ID     = 12'h5A3,  // Arbitrary value.
	parameter logic [15:0] WAFER_REVISION = 16'h0001, // Arbitrary value.
	parameter int          TIMER_COUNT    = 8
) (
	input  wire logic                   clk_i,                          // Clock, 250 MHz.
	input  wire logic                   rst_i,                          // System reset.
	input  wire logic                   por_i,                          // Power-on reset.
	input  wire logic                   cyc_i,                          // Wishbone cycle.
	input  wire logic                   stb_i,                          // Wishbone strobe.
	input  wire logic                   we_i,                           // Wishbone write.
	input  wire logic [31:0]            adr_i,                          // Byte address.
	input  wire logic [3:0]             sel_i,                          // Byte selects.
	input  wire logic [31:0]            dat_i,                          // Write data.
	output logic [31:0]                 dat_o,                          // Read data.
	output logic                        ack_o,                          // Normal answer.
	output logic                        err_o,                          // Error answer.
	input  wire logic                   core_halted_i,                  // Core halted.
	input  wire power_mode_type         power_mode_i,                   // Power state.
	output logic                        core_clock_run_o,               // Core clock on.
	output logic                        ahb_clock_run_o,                // AHB clock on.
	output logic                        rc_clock_source_o,              // Clocks from RC.
	output logic                        sleep_debug_clock_keep_o,       // Config bit 0.
	output logic                        halt_lowpower_debug_clock_keep_o, // Config bit 1.
	output logic                        deep_lowpower_debug_clock_keep_o, // Config bit 2.
	output logic                        trace_pins_on_o,                // Trace pins on.
	output logic [1:0]                  trace_mode_o,                   // Trace mode.
	output logic [2:0]                  trace_lanes_o,                  // Trace lanes.
	output logic                        independent_watchdog_freeze_o,  // Freeze.
	output logic                        window_watchdog_freeze_o,       // Freeze.
	output logic [TIMER_COUNT-1:0]      timer_freeze_o,                 // Freezes.
	output logic                        first_can_freeze_o,             // Freeze.
	output logic                        second_can_freeze_o,            // Freeze.
	output logic                        first_smbus_timeout_freeze_o,   // Freeze.
	output logic                        second_smbus_timeout_freeze_o   // Freeze.
);

	slave_state_type   state_reg;
	slave_state_type   state_next;
	config_fields_type written;
	logic              hit_id;
	logic              hit_cfg;
	logic              bad;
	logic              req_new;
	logic              wr_commit;
	logic              any_reset;
	logic [31:0]       id_word;
	logic [1:0]        wd_freeze;
	logic [1:0]        can_freeze;
	logic [1:0]        smbus_freeze;

	// Address and byte-select decode of the current request.
	wb_word_decode u_decode (
		.adr_i     (adr_i),
		.sel_i     (sel_i),
		.hit_id_o  (hit_id),
		.hit_cfg_o (hit_cfg),
		.bad_o     (bad)
	);

	// The identification word is fixed; its reserved nibble reads zero.
	assign id_word = {WAFER_REVISION, ID_RESERVED, DEVICE_ID}; // RULE_01 RULE_02

	assign any_reset = rst_i || por_i;

	// Request taking, read data, configuration update and clock decode.
	always_comb begin
		state_next = state_reg;
		written    = state_reg.cfg;
		req_new    = cyc_i && stb_i && !state_reg.ack && !state_reg.err;
		wr_commit  = state_reg.ack && cyc_i && stb_i && we_i && hit_cfg;
		state_next.ack   = 1'b0;
		state_next.err   = 1'b0;
		state_next.rdata = 32'h0000_0000;
		if (req_new) begin
			if (bad) begin
				state_next.err = 1'b1; // RULE_03
			end else begin
				state_next.ack   = 1'b1;
				state_next.rdata = hit_id ? id_word
					: (32'(state_reg.cfg) & CONFIG_WRITE_MASK); // RULE_17
			end
		end
		// A write lands at the edge where the master samples the answer.
		if (wr_commit) begin
			written = config_fields_type'(dat_i & CONFIG_WRITE_MASK); // RULE_08 RULE_16
			if (!written.trace_pins_on) begin
				written.trace_mode = state_reg.cfg.trace_mode; // RULE_09
			end
			state_next.cfg = written;
		end
		// Clock selection for the debugged power states.
		case (power_mode_i)
			POWER_RUN: begin
				state_next.core_clock_run  = 1'b1;
				state_next.ahb_clock_run   = 1'b1;
				state_next.rc_clock_source = 1'b0;
			end
			POWER_SLEEP: begin
				state_next.core_clock_run  = 1'b1; // RULE_05
				state_next.ahb_clock_run   = state_reg.cfg.sleep_debug_clock_keep;
				state_next.rc_clock_source = 1'b0;
			end
			POWER_HALT_LOWPOWER: begin
				state_next.core_clock_run  = state_reg.cfg.halt_lowpower_debug_clock_keep;
				state_next.ahb_clock_run   = state_reg.cfg.halt_lowpower_debug_clock_keep;
				state_next.rc_clock_source = state_reg.cfg.halt_lowpower_debug_clock_keep; // RULE_06
			end
			POWER_DEEP_LOWPOWER: begin
				state_next.core_clock_run  = state_reg.cfg.deep_lowpower_debug_clock_keep;
				state_next.ahb_clock_run   = state_reg.cfg.deep_lowpower_debug_clock_keep;
				state_next.rc_clock_source = state_reg.cfg.deep_lowpower_debug_clock_keep; // RULE_07
			end
			default: begin
				state_next.core_clock_run  = 1'b1;
				state_next.ahb_clock_run   = 1'b1;
				state_next.rc_clock_source = 1'b0;
			end
		endcase
		// Number of trace data lanes for the selected mode.
		if (!state_reg.cfg.trace_pins_on) begin
			state_next.trace_lanes = TRACE_LANES_NONE; // RULE_08
		end else begin
			case (state_reg.cfg.trace_mode)
				TRACE_MODE_ASYNC: state_next.trace_lanes = TRACE_LANES_NONE; // RULE_09
				TRACE_MODE_SYNC1: state_next.trace_lanes = TRACE_LANES_ONE;
				TRACE_MODE_SYNC2: state_next.trace_lanes = TRACE_LANES_TWO;
				TRACE_MODE_SYNC4: state_next.trace_lanes = TRACE_LANES_FOUR;
				default:          state_next.trace_lanes = TRACE_LANES_NONE;
			endcase
		end
		// System reset clears the bus side but leaves the configuration alone.
		if (rst_i) begin
			state_next     = STATE_RESET;
			state_next.cfg = state_reg.cfg; // RULE_04
		end
	end

	// Only power-on reset clears the whole state, configuration included.
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			state_reg <= STATE_RESET; // RULE_04
		end else begin
			state_reg <= state_next;
		end
	end

	// Register outputs.
	assign dat_o                            = state_reg.rdata;
	assign ack_o                            = state_reg.ack;
	assign err_o                            = state_reg.err;
	assign core_clock_run_o                 = state_reg.core_clock_run;
	assign ahb_clock_run_o                  = state_reg.ahb_clock_run;
	assign rc_clock_source_o                = state_reg.rc_clock_source;
	assign sleep_debug_clock_keep_o         = state_reg.cfg.sleep_debug_clock_keep;
	assign halt_lowpower_debug_clock_keep_o = state_reg.cfg.halt_lowpower_debug_clock_keep;
	assign deep_lowpower_debug_clock_keep_o = state_reg.cfg.deep_lowpower_debug_clock_keep;
	assign trace_pins_on_o                  = state_reg.cfg.trace_pins_on;
	assign trace_mode_o                     = state_reg.cfg.trace_mode;
	assign trace_lanes_o                    = state_reg.trace_lanes;

	// Watchdog freezes, independent in bit 0 and window in bit 1.
	freeze_stage #(
		.WIDTH (2)
	) u_wd_freeze (
		.clk_i    (clk_i),
		.rst_i    (any_reset),
		.enable_i ({state_reg.cfg.window_watchdog_freeze,
			state_reg.cfg.independent_watchdog_freeze}), // RULE_10 RULE_11
		.halted_i (core_halted_i),
		.frozen_o (wd_freeze)
	);

	// Timer freezes, low group in bits 3:0 and high group in bits 7:4.
	freeze_stage #(
		.WIDTH (TIMER_COUNT)
	) u_timer_freeze (
		.clk_i    (clk_i),
		.rst_i    (any_reset),
		.enable_i (TIMER_COUNT'({state_reg.cfg.timer_freeze_high,
			state_reg.cfg.timer_freeze_low})), // RULE_12
		.halted_i (core_halted_i),
		.frozen_o (timer_freeze_o)
	);

	// CAN freezes, first in bit 0 and second in bit 1.
	freeze_stage #(
		.WIDTH (2)
	) u_can_freeze (
		.clk_i    (clk_i),
		.rst_i    (any_reset),
		.enable_i ({state_reg.cfg.second_can_freeze,
			state_reg.cfg.first_can_freeze}), // RULE_13 RULE_16
		.halted_i (core_halted_i),
		.frozen_o (can_freeze)
	);

	// SMBus timeout freezes, first in bit 0 and second in bit 1.
	freeze_stage #(
		.WIDTH (2)
	) u_smbus_freeze (
		.clk_i    (clk_i),
		.rst_i    (any_reset),
		.enable_i ({state_reg.cfg.second_smbus_timeout_freeze,
			state_reg.cfg.first_smbus_timeout_freeze}), // RULE_14 RULE_15
		.halted_i (core_halted_i),
		.frozen_o (smbus_freeze)
	);

	// Freeze outputs by peripheral.
	assign independent_watchdog_freeze_o = wd_freeze[0];
	assign window_watchdog_freeze_o      = wd_freeze[1];
	assign first_can_freeze_o            = can_freeze[0];
	assign second_can_freeze_o           = can_freeze[1];
	assign first_smbus_timeout_freeze_o  = smbus_freeze[0];
	assign second_smbus_timeout_freeze_o = smbus_freeze[1];

	// Checks of the block against its documented behaviour.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (any_reset);

	sequence s_read_id;
		cyc_i && stb_i && !we_i && !ack_o && !err_o && adr_i == CHIP_IDENTIFICATION_ADDR
			&& sel_i == FULL_WORD_SEL;
	endsequence

	a_id_device_code: assert property ( // RULE_01
		s_read_id |=> ack_o && !err_o && dat_o[11:0] == DEVICE_ID)
		else $error("identification read returned the wrong device code");

	a_id_upper_fields: assert property ( // RULE_02
		s_read_id |=> dat_o[15:12] == 4'h0 && dat_o[31:16] == WAFER_REVISION)
		else $error("identification read returned wrong wafer or reserved bits");

	a_partial_word_err: assert property ( // RULE_03
		cyc_i && stb_i && !ack_o && !err_o && sel_i != FULL_WORD_SEL
			|=> err_o && !ack_o ##1 !err_o)
		else $error("partial word access was not refused for one cycle");

	a_cfg_survives_rst: assert property (@(posedge clk_i) disable iff (por_i) // RULE_04
		rst_i |=> state_reg.cfg == $past(state_reg.cfg))
		else $error("system reset disturbed the configuration");

	a_cfg_por_clear: assert property (@(posedge clk_i) disable iff (1'b0) // RULE_04
		por_i |=> 32'(state_reg.cfg) == CONFIG_RESET && !ack_o && !err_o)
		else $error("power-on reset did not clear the configuration");

	a_sleep_clocks: assert property ( // RULE_05
		power_mode_i == POWER_SLEEP && !rst_i
			|=> core_clock_run_o && !rc_clock_source_o
			&& ahb_clock_run_o == $past(state_reg.cfg.sleep_debug_clock_keep))
		else $error("sleep clock selection wrong");

	a_halt_lp_clocks: assert property ( // RULE_06
		power_mode_i == POWER_HALT_LOWPOWER && !rst_i
			|=> core_clock_run_o == $past(halt_lowpower_debug_clock_keep_o)
			&& ahb_clock_run_o == core_clock_run_o && rc_clock_source_o == core_clock_run_o)
		else $error("halt low-power clock selection wrong");

	a_deep_lp_clocks: assert property ( // RULE_07
		power_mode_i == POWER_DEEP_LOWPOWER && !rst_i
			|=> core_clock_run_o == $past(deep_lowpower_debug_clock_keep_o)
			&& ahb_clock_run_o == core_clock_run_o && rc_clock_source_o == core_clock_run_o)
		else $error("deep low-power clock selection wrong");

	a_trace_lanes_off: assert property ( // RULE_08
		!trace_pins_on_o ##1 !trace_pins_on_o |-> trace_lanes_o == TRACE_LANES_NONE)
		else $error("trace lanes active with trace pins off");

	a_trace_mode_lock: assert property ( // RULE_09
		wr_commit && !dat_i[CFG_TRACE_ON_POS] |=> $stable(trace_mode_o))
		else $error("trace mode changed while trace pins disabled");

	a_iwd_freeze: assert property ( // RULE_10
		!rst_i |=> independent_watchdog_freeze_o
			== $past(state_reg.cfg.independent_watchdog_freeze && core_halted_i))
		else $error("independent watchdog freeze wrong");

	a_wwd_freeze: assert property ( // RULE_11
		!rst_i |=> window_watchdog_freeze_o
			== $past(state_reg.cfg.window_watchdog_freeze && core_halted_i))
		else $error("window watchdog freeze wrong");

	a_timer_freeze: assert property ( // RULE_12
		!rst_i |=> timer_freeze_o == $past({state_reg.cfg.timer_freeze_high,
			state_reg.cfg.timer_freeze_low} & {TIMER_COUNT{core_halted_i}}))
		else $error("timer freeze wrong");

	a_can_freeze: assert property ( // RULE_13 RULE_16
		!rst_i |=> {second_can_freeze_o, first_can_freeze_o} == $past({
			state_reg.cfg.second_can_freeze, state_reg.cfg.first_can_freeze}
			& {2{core_halted_i}}))
		else $error("CAN freeze wrong");

	a_smbus_freeze: assert property ( // RULE_14 RULE_15
		!rst_i |=> {second_smbus_timeout_freeze_o, first_smbus_timeout_freeze_o} == $past({
			state_reg.cfg.second_smbus_timeout_freeze,
			state_reg.cfg.first_smbus_timeout_freeze} & {2{core_halted_i}}))
		else $error("SMBus timeout freeze wrong");

	a_reserved_zero: assert property ( // RULE_17
		ack_o && !$past(hit_id) |-> (dat_o & ~CONFIG_WRITE_MASK) == 32'h0000_0000)
		else $error("reserved configuration bits read as one");

	// Main scenarios worth seeing in simulation.
	c_cfg_write: cover property (wr_commit ##2 trace_lanes_o == TRACE_LANES_FOUR);
	c_unmapped_err: cover property (cyc_i && stb_i && bad ##1 err_o);
	c_halted_freeze: cover property (core_halted_i ##1 timer_freeze_o != '0);
	c_rst_keeps_cfg: cover property (@(posedge clk_i) disable iff (por_i)
		rst_i && 32'(state_reg.cfg) != CONFIG_RESET);

endmodule

// ==== testbench/core_halt_model.sv ====
// Behavioural model of the core halt logic and the power controller.
`timescale 1ns/10ps
module core_halt_model
	import debug_support_pkg::*;
(
	input  wire logic           clk_i,                      // Block clock.
	input  wire logic           halt_req_i,                 // Bench asks for a halt.
	input  wire power_mode_type mode_req_i,                 // Bench asks for a power state.
	output logic                core_halted_o = 1'b0,       // Core halted indication.
	output power_mode_type      power_mode_o  = POWER_RUN   // Reported power state.
);
	// Indications change only just after an edge, as the real halt logic does.
	always_ff @(posedge clk_i) begin
		core_halted_o <= halt_req_i;
		power_mode_o  <= mode_req_i;
	end
endmodule

// ==== testbench/debug_support_config_regs_bench.sv ====
// Self-checking bench of the debug support register block.
`timescale 1ns/10ps
module debug_support_config_regs_bench;
	import debug_support_pkg::*;
	logic           clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
	logic           cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, halt_req = 1'b0;
	logic [31:0]    adr_i = 32'h0, dat_i = 32'h0, dat_o, cfg_m, q;
	logic [3:0]     sel_i = 4'h0;
	logic           ack_o, err_o, core_halted, e, core_run, ahb_run, rc_src;
	logic           slp_keep, halt_keep, deep_keep, trace_on, iwd, wwd, can1, can2, smb1, smb2;
	logic [1:0]     trace_mode;
	logic [2:0]     lanes;
	logic [7:0]     timers;
	power_mode_type mode_req = POWER_RUN, power_mode;
	int             fail_count = 0, samples_checked = 0, cycles = 0;

	debug_support_config_regs i_debug_support_config_regs (.clk_i(clk_i), .rst_i(rst_i),
		.por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .core_halted_i(core_halted),
		.power_mode_i(power_mode), .core_clock_run_o(core_run), .ahb_clock_run_o(ahb_run),
		.rc_clock_source_o(rc_src), .sleep_debug_clock_keep_o(slp_keep),
		.halt_lowpower_debug_clock_keep_o(halt_keep), .deep_lowpower_debug_clock_keep_o(deep_keep),
		.trace_pins_on_o(trace_on), .trace_mode_o(trace_mode), .trace_lanes_o(lanes),
		.independent_watchdog_freeze_o(iwd), .window_watchdog_freeze_o(wwd),
		.timer_freeze_o(timers), .first_can_freeze_o(can1), .second_can_freeze_o(can2),
		.first_smbus_timeout_freeze_o(smb1), .second_smbus_timeout_freeze_o(smb2));
	core_halt_model i_core_halt_model (.clk_i(clk_i), .halt_req_i(halt_req),
		.mode_req_i(mode_req), .core_halted_o(core_halted), .power_mode_o(power_mode));

	// Clock at 250 MHz and a hang limit well beyond the planned run.
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// Counts one comparison and reports a mismatch.
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic Wishbone cycle; the request stands until ack or err is sampled.
	task wb(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
		q = dat_o;
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Writes the configuration word and updates the model; mode bits need bit 5.
	task cfg_write(input logic [31:0] d);
		logic [31:0] nd;
		nd = d & CONFIG_WRITE_MASK;
		if (!d[5]) begin
			nd[7:6] = cfg_m[7:6];
		end
		wb(1'b1, DEBUG_BEHAVIOUR_CONFIG_ADDR, FULL_WORD_SEL, d);
		chk("write err", 32'(e), 32'h0);
		cfg_m = nd;
	endtask

	// Reads the configuration word back against the model.
	task cfg_read();
		wb(1'b0, DEBUG_BEHAVIOUR_CONFIG_ADDR, FULL_WORD_SEL, 32'h0);
		chk("config", q, cfg_m);
	endtask

	// Lets derived outputs settle, then compares them with the model.
	task check_outputs();
		logic [2:0] exp_lanes;
		logic [2:0] exp_clk;
		repeat (3) @(posedge clk_i);
		#1;
		exp_lanes = (cfg_m[5] && cfg_m[7:6] != 2'h0) ? 3'(1 << (cfg_m[7:6] - 2'h1)) : 3'h0;
		case (power_mode)
			POWER_RUN: exp_clk = 3'h6;
			POWER_SLEEP: exp_clk = {1'b1, cfg_m[0], 1'b0};
			POWER_HALT_LOWPOWER: exp_clk = {3{cfg_m[1]}};
			default: exp_clk = {3{cfg_m[2]}};
		endcase
		chk("clocks", 32'({core_run, ahb_run, rc_src}), 32'(exp_clk));
		chk("cfg bits", 32'({trace_mode, trace_on, deep_keep, halt_keep, slp_keep}),
			32'({cfg_m[7:5], cfg_m[2:0]}));
		chk("lanes", 32'(lanes), 32'(exp_lanes));
		chk("freezes", 32'({can2, timers[7:4], smb2, smb1, can1, timers[3:0], wwd, iwd}),
			core_halted ? 32'(cfg_m[21:8]) : 32'h0);
		@(posedge clk_i);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task tally_and_finish();
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Main sequence: identification, trace modes, random words, refusals, resets.
	initial begin
		void'($urandom(81287));
		cfg_m = CONFIG_RESET;
		repeat (12) @(posedge clk_i);
		por_i <= 1'b0;
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, CHIP_IDENTIFICATION_ADDR, FULL_WORD_SEL, 32'hFFFF_FFFF);
		wb(1'b0, CHIP_IDENTIFICATION_ADDR, FULL_WORD_SEL, 32'h0);
		chk("ident", q, {16'h0001, 4'h0, 12'h5A3});
		cfg_read();
		for (int t = 0; t < 4; t++) begin
			cfg_write(32'h20 | (t << 6));
			check_outputs();
		end
		cfg_write(32'h0000_0040);
		check_outputs();
		for (int i = 0; i < 6; i++) begin
			cfg_write($urandom);
			cfg_read();
			for (int h = 0; h < 2; h++) begin
				for (int m = 0; m < 4; m++) begin
					halt_req <= h[0];
					mode_req <= power_mode_type'(m);
					check_outputs();
				end
			end
		end
		wb(1'b0, DEBUG_BEHAVIOUR_CONFIG_ADDR + 32'h8, FULL_WORD_SEL, 32'h0);
		chk("unmapped", {31'h0, e} | q, 32'h1);
		wb(1'b1, DEBUG_BEHAVIOUR_CONFIG_ADDR, 4'h3, ~cfg_m);
		chk("partial", 32'(e), 32'h1);
		cfg_read();
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		cfg_read();
		check_outputs();
		por_i <= 1'b1;
		@(posedge clk_i);
		por_i <= 1'b0;
		@(posedge clk_i);
		cfg_m = CONFIG_RESET;
		cfg_read();
		tally_and_finish();
	end
endmodule
